/* File: include/cfe_consts.svh */
// cfe_consts.svh: offsets, bit positions, reset values and limits
// assumes: included by bare name from package and design files
`ifndef CFE_CONSTS_SVH
`define CFE_CONSTS_SVH
`define CFE_OFS_IRQ_FLAGS 10'h228
`define CFE_OFS_FE_STATUS 10'h22c
`define CFE_OFS_FE_ENABLE 10'h22e
`define CFE_OFS_TX_ERR_CNT 10'h274
`define CFE_OFS_RX_ERR_CNT 10'h275
`define CFE_OFS_WARN_LIMIT 10'h276
`define CFE_OFS_ERR_CODE 10'h278
`define CFE_OFS_ARB_LOST 10'h27a
`define CFE_OFS_CORE_CTRL 10'h27c
`define CFE_OFS_CORE_STATUS 10'h27d
`define CFE_BIT_PBO 5
`define CFE_BIT_ARB 4
`define CFE_BIT_BUS_ERROR_FLAG 3
`define CFE_BIT_BUS_OFF_CHANGE_FLAG 2
`define CFE_BIT_WARN 1
`define CFE_BIT_PASS 0
`define CFE_BIT_FRAME_FAULT_IRQ_FLAG 4
`define CFE_BIT_MSG_FAULT_IRQ_FLAG 3
`define CFE_BIT_RX_BUFFER_FULL_IRQ_FLAG 2
`define CFE_BIT_TX_DONE_IRQ_FLAG 1
`define CFE_BIT_RX_DONE_IRQ_FLAG 0
`define CFE_BIT_BS 7
`define CFE_BIT_EP 6
`define CFE_BIT_EW 5
`define CFE_PASSIVE_LIMIT 9'h080
`define CFE_BUS_OFF_CHANGE_FLAG_TX_PRESET 8'h7f
`define CFE_TX_CNT_MAX 9'h0ff
`define CFE_WARN_LIMIT_RST 8'h60
`define CFE_RST_BYTE 8'h00
`define CFE_PREBUF_BYTES 13
`endif

/* File: include/cfe_pkg.sv */
// cfe_pkg: types shared by the frame-error block
// assumes: cfe_consts.svh reachable on the include path
package cfe_pkg;
  `include "cfe_consts.svh"
  typedef enum logic [1:0] {BUS_ERROR_FLAG_BIT, BUS_ERROR_FLAG_FORM, BUS_ERROR_FLAG_STUFF, BUS_ERROR_FLAG_OTHER}
    cfe_err_type_t;
  typedef logic [4:0] cfe_field_t;
  typedef logic [7:0] cfe_byte_t;
  typedef logic [9:0] cfe_addr_t;
endpackage

/* File: include/cfe_prebuf_if.sv */
// cfe_prebuf_if: link between the error core and its pre-buffer tracker
// assumes: one clock, driven inside the frame-error top
`timescale 1ns/1ps
interface cfe_prebuf_if;
  logic overflow;
  logic rx_byte;
  logic rx_eof;
  logic drained;
  modport core (input overflow, output rx_byte, output rx_eof,
    output drained);
  modport buf_side (output overflow, input rx_byte, input rx_eof,
    input drained);
endinterface

/* File: core/cfe_prebuf.sv */
// cfe_prebuf: receive pre-buffer occupancy and overflow detection
// assumes: byte and end-of-frame strobes from the bit engine
`timescale 1ns/1ps
module cfe_prebuf (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  cfe_prebuf_if.buf_side pb
);
  import cfe_pkg::*;
  logic [3:0] cnt_ff;
  logic held_ff;
  logic drop_ff;
  // one stored frame is held until drained, the next frame fills cnt_ff
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      held_ff <= 1'b0;
    end else if (ce) begin
      if (pb.rx_eof && !drop_ff && !held_ff) begin
        held_ff <= 1'b1;
      end else if (pb.drained) begin
        held_ff <= 1'b0;
      end
    end
  end
  // extra bytes beyond capacity are ignored once overflow is seen
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_ff <= 4'h0;
      drop_ff <= 1'b0;
    end else if (ce) begin
      if (pb.rx_eof) begin
        cnt_ff <= 4'h0;
        drop_ff <= 1'b0;
      end else if (pb.rx_byte && !drop_ff) begin
        if (held_ff && cnt_ff == 4'(`CFE_PREBUF_BYTES)) begin
          drop_ff <= 1'b1;
        end else if (cnt_ff != 4'(`CFE_PREBUF_BYTES)) begin
          cnt_ff <= cnt_ff + 4'h1;
        end
      end
    end
  end
  // raised on byte arrival, before any acceptance filtering
  assign pb.overflow = ce && pb.rx_byte && !drop_ff && held_ff &&
    cnt_ff == 4'(`CFE_PREBUF_BYTES);
endmodule // cfe_prebuf

/* File: core/cfe_frame_err.sv */
// cfe_frame_err: bus-error/arb-lost capture, fault confinement, flags
// assumes: bit engine on CORE_CLK supplies strobes; cpu byte port
`timescale 1ns/1ps
`include "cfe_consts.svh"
// Summary of operation
// - bus error code stores type in 7:6 and direction in bit 5
// - bits 4:0 of the error code hold the frame field code
// - pre-buffer holds one whole frame of up to 13 bytes
// - overflow drops further bytes and sets flag bit 5, write-one-clear
// - overflow is flagged before filtering, with no object number
// - arbitration loss sets flag bit 4, cleared by reading capture
// - arb capture holds position in 4:0, bits 7:5 read zero
// - position code counts from 0 at ID28 up to 31 for RTR
// - no new arb capture until the cpu has read the register
// - warning bit set when a counter reaches limit, clear when both below
// - warning change flag sets on both edges, write-one-clear
// - passive bit set at 128 or more, clears when both below 128
// - passive change flag sets on both edges, write-one-clear
// - tx counter over 255 gives bus-off, hold request, tx 127, rx 0
// - bus state bit is 1 while bus-off until recovery completes
// - after release, 128 bus-free events return bus-on with counters 0
// - any tx value but 127 written while bus-off, before the first bus-free event, gives one-event recovery
// - tx counter takes cpu writes only in reset mode
// - irq flags at 228h, bits 4:2 write-one-clear (4 only once status is clear), done bits 1:0 mirror inputs
// - status at 22Ch, bus error flag clears on error code read
// - enable register at 22Eh, one enable per status bit
// - an enabled hardware-set status flag sets the frame irq flag
// - bus error sets flag bit 3, no new code until read
module cfe_frame_err (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic CLK_EN,
  input wire cfe_pkg::cfe_addr_t REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire cfe_pkg::cfe_byte_t REG_WDATA,
  output logic [7:0] REG_RDATA,
  input wire logic BUS_ERR,
  input wire cfe_pkg::cfe_err_type_t BUS_ERR_TYPE,
  input wire logic BUS_ERR_RX,
  input wire cfe_pkg::cfe_field_t BUS_ERR_FIELD,
  input wire logic ARB_LOST,
  input wire cfe_pkg::cfe_field_t ARB_LOST_POS,
  input wire logic TX_ERR_INC,
  input wire logic TX_ERR_INC8,
  input wire logic RX_ERR_INC,
  input wire logic TX_ERR_DEC,
  input wire logic RX_ERR_DEC,
  input wire logic BUS_FREE,
  input wire logic RX_BYTE,
  input wire logic RX_EOF,
  input wire logic PREBUF_DRAINED,
  input wire logic MSG_ERR_SET,
  input wire logic RX_FULL_SET,
  input wire logic TX_DONE,
  input wire logic RX_DONE,
  output logic CORE_HOLD,
  output logic BUS_OFF,
  output logic FRAME_IRQ
);
  import cfe_pkg::*;
  cfe_prebuf_if pbi ();
  logic [5:0] fes_ff, fee_ff, fes_set;
  logic [4:0] irq_ff;
  logic [7:0] ecc_ff, alc_ff, txc_ff, rxc_ff, ewl_ff;
  logic ecc_lock_ff, alc_lock_ff, hold_ff, bs_ff, ew_ff, ep_ff;
  logic [7:0] bus_off_change_flag_left_ff;
  logic wr_stat, wr_irq, rd_ecc, rd_alc, wr_tx, nxt_ew, nxt_ep;
  logic [8:0] nxt_tx;
  logic bus_off_change_flag_enter, bus_off_change_flag_exit, fast_rec, forced_ff;
  logic [8:0] tx_w, rx_w;

  assign pbi.rx_byte = RX_BYTE;
  assign pbi.rx_eof = RX_EOF;
  assign pbi.drained = PREBUF_DRAINED;
  cfe_prebuf u_prebuf (
    .clk(CORE_CLK),
    .rst_n(RESET_N),
    .ce(CLK_EN),
    .pb(pbi)
  );

  assign wr_stat = CLK_EN && REG_WR && REG_ADDR == `CFE_OFS_FE_STATUS;
  assign wr_irq = CLK_EN && REG_WR && REG_ADDR == `CFE_OFS_IRQ_FLAGS;
  assign rd_ecc = CLK_EN && REG_RD && REG_ADDR == `CFE_OFS_ERR_CODE;
  assign rd_alc = CLK_EN && REG_RD && REG_ADDR == `CFE_OFS_ARB_LOST;
  assign wr_tx = CLK_EN && REG_WR && REG_ADDR == `CFE_OFS_TX_ERR_CNT;

  // bus error capture, frozen until read
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      ecc_ff <= `CFE_RST_BYTE;
      ecc_lock_ff <= 1'b0;
    end else if (CLK_EN) begin
      if (BUS_ERR && !ecc_lock_ff) begin
        ecc_ff <= {BUS_ERR_TYPE, BUS_ERR_RX, BUS_ERR_FIELD};
        ecc_lock_ff <= 1'b1;
      end else if (rd_ecc) begin
        ecc_lock_ff <= 1'b0;
      end
    end
  end

  // arbitration-lost capture, re-armed only by a read
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      alc_ff <= `CFE_RST_BYTE;
      alc_lock_ff <= 1'b0;
    end else if (CLK_EN) begin
      if (ARB_LOST && !alc_lock_ff) begin
        alc_ff <= {3'h0, ARB_LOST_POS};
        alc_lock_ff <= 1'b1;
      end else if (rd_alc) begin
        alc_lock_ff <= 1'b0;
      end
    end
  end

  // counter arithmetic on 9 bits so overflow past 255 is visible
  always_comb begin
    tx_w = {1'b0, txc_ff};
    rx_w = {1'b0, rxc_ff};
    if (!hold_ff && !bs_ff) begin
      if (TX_ERR_INC8) begin
        tx_w = tx_w + 9'h008;
      end else if (TX_ERR_INC) begin
        tx_w = tx_w + 9'h001;
      end else if (TX_ERR_DEC && tx_w != 9'h000) begin
        tx_w = tx_w - 9'h001;
      end
      if (RX_ERR_INC && rx_w != 9'h0ff) begin
        rx_w = rx_w + 9'h001;
      end else if (RX_ERR_DEC && rx_w != 9'h000) begin
        rx_w = rx_w - 9'h001;
      end
    end
    nxt_tx = tx_w;
  end
  // only a written 255 forces entry; a counted 255 is still bus-on
  assign bus_off_change_flag_enter = !bs_ff && !hold_ff &&
    (nxt_tx > `CFE_TX_CNT_MAX || forced_ff);
  // fast path only before the first event, else decrements would trip it
  assign fast_rec = bus_off_change_flag_left_ff == 8'h80 &&
    txc_ff != `CFE_BUS_OFF_CHANGE_FLAG_TX_PRESET;
  assign bus_off_change_flag_exit = bs_ff && !hold_ff && BUS_FREE &&
    (fast_rec || bus_off_change_flag_left_ff == 8'h01);

  // fault confinement counters and bus state
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      txc_ff <= `CFE_RST_BYTE;
      rxc_ff <= `CFE_RST_BYTE;
      bs_ff <= 1'b0;
      bus_off_change_flag_left_ff <= 8'h00;
    end else if (CLK_EN) begin
      if (bus_off_change_flag_enter) begin
        bs_ff <= 1'b1;
        txc_ff <= `CFE_BUS_OFF_CHANGE_FLAG_TX_PRESET;
        rxc_ff <= `CFE_RST_BYTE;
        bus_off_change_flag_left_ff <= 8'h80;
      end else if (bus_off_change_flag_exit) begin
        bs_ff <= 1'b0;
        txc_ff <= `CFE_RST_BYTE;
        rxc_ff <= `CFE_RST_BYTE;
      end else if (wr_tx && hold_ff) begin
        txc_ff <= REG_WDATA;
      end else if (bs_ff && !hold_ff && BUS_FREE) begin
        txc_ff <= txc_ff - 8'h01;
        bus_off_change_flag_left_ff <= bus_off_change_flag_left_ff - 8'h01;
      end else if (!bs_ff) begin
        txc_ff <= nxt_tx[7:0];
        rxc_ff <= rx_w[7:0];
      end
    end
  end

  // reset-mode request and warning limit
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      hold_ff <= 1'b1;
      ewl_ff <= `CFE_WARN_LIMIT_RST;
      forced_ff <= 1'b0;
    end else if (CLK_EN) begin
      if (bus_off_change_flag_enter) begin
        forced_ff <= 1'b0;
      end else if (wr_tx && hold_ff && !bs_ff) begin
        forced_ff <= REG_WDATA == 8'hff;
      end
      if (bus_off_change_flag_enter) begin
        hold_ff <= 1'b1;
      end else if (REG_WR && REG_ADDR == `CFE_OFS_CORE_CTRL) begin
        hold_ff <= REG_WDATA[0];
      end
      if (REG_WR && REG_ADDR == `CFE_OFS_WARN_LIMIT && hold_ff) begin
        ewl_ff <= REG_WDATA;
      end
    end
  end

  assign nxt_ew = txc_ff >= ewl_ff || rxc_ff >= ewl_ff;
  assign nxt_ep = {1'b0, txc_ff} >= `CFE_PASSIVE_LIMIT ||
    {1'b0, rxc_ff} >= `CFE_PASSIVE_LIMIT;
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      ew_ff <= 1'b0;
      ep_ff <= 1'b0;
    end else if (CLK_EN) begin
      ew_ff <= nxt_ew;
      ep_ff <= nxt_ep;
    end
  end

  // hardware set events per status bit
  always_comb begin
    fes_set = 6'h00;
    fes_set[`CFE_BIT_PBO] = pbi.overflow;
    fes_set[`CFE_BIT_ARB] = ARB_LOST && !alc_lock_ff;
    fes_set[`CFE_BIT_BUS_ERROR_FLAG] = BUS_ERR && !ecc_lock_ff;
    fes_set[`CFE_BIT_BUS_OFF_CHANGE_FLAG] = bus_off_change_flag_enter || bus_off_change_flag_exit;
    fes_set[`CFE_BIT_WARN] = nxt_ew != ew_ff;
    fes_set[`CFE_BIT_PASS] = nxt_ep != ep_ff;
  end

  // status flags: set wins over any clear
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      fes_ff <= 6'h00;
    end else if (CLK_EN) begin
      for (int i = 0; i < 6; i++) begin
        if (fes_set[i]) begin
          fes_ff[i] <= 1'b1;
        end else if (i == `CFE_BIT_ARB && rd_alc) begin
          fes_ff[i] <= 1'b0;
        end else if (i == `CFE_BIT_BUS_ERROR_FLAG && rd_ecc) begin
          fes_ff[i] <= 1'b0;
        end else if (i != `CFE_BIT_ARB && i != `CFE_BIT_BUS_ERROR_FLAG &&
            wr_stat && REG_WDATA[i]) begin
          fes_ff[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      fee_ff <= 6'h00;
    end else if (CLK_EN && REG_WR && REG_ADDR == `CFE_OFS_FE_ENABLE) begin
      fee_ff <= REG_WDATA[5:0];
    end
  end

  // frame_fault_irq_flag clears only once every status flag is already clear
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      irq_ff <= 5'h00;
    end else if (CLK_EN) begin
      if (|(fes_set & fee_ff)) begin
        irq_ff[`CFE_BIT_FRAME_FAULT_IRQ_FLAG] <= 1'b1;
      end else if (wr_irq && REG_WDATA[`CFE_BIT_FRAME_FAULT_IRQ_FLAG] && fes_ff == 6'h00)
      begin
        irq_ff[`CFE_BIT_FRAME_FAULT_IRQ_FLAG] <= 1'b0;
      end
      if (MSG_ERR_SET) begin
        irq_ff[`CFE_BIT_MSG_FAULT_IRQ_FLAG] <= 1'b1;
      end else if (wr_irq && REG_WDATA[`CFE_BIT_MSG_FAULT_IRQ_FLAG]) begin
        irq_ff[`CFE_BIT_MSG_FAULT_IRQ_FLAG] <= 1'b0;
      end
      if (RX_FULL_SET) begin
        irq_ff[`CFE_BIT_RX_BUFFER_FULL_IRQ_FLAG] <= 1'b1;
      end else if (wr_irq && REG_WDATA[`CFE_BIT_RX_BUFFER_FULL_IRQ_FLAG]) begin
        irq_ff[`CFE_BIT_RX_BUFFER_FULL_IRQ_FLAG] <= 1'b0;
      end
      // completion flags are cleared by their own message logic elsewhere
      irq_ff[`CFE_BIT_TX_DONE_IRQ_FLAG] <= TX_DONE;
      irq_ff[`CFE_BIT_RX_DONE_IRQ_FLAG] <= RX_DONE;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      REG_RDATA <= 8'h00;
    end else if (CLK_EN && REG_RD) begin
      unique case (REG_ADDR)
        `CFE_OFS_IRQ_FLAGS: REG_RDATA <= {3'h0, irq_ff};
        `CFE_OFS_FE_STATUS: REG_RDATA <= {2'h0, fes_ff};
        `CFE_OFS_FE_ENABLE: REG_RDATA <= {2'h0, fee_ff};
        `CFE_OFS_TX_ERR_CNT: REG_RDATA <= txc_ff;
        `CFE_OFS_RX_ERR_CNT: REG_RDATA <= rxc_ff;
        `CFE_OFS_WARN_LIMIT: REG_RDATA <= ewl_ff;
        `CFE_OFS_ERR_CODE: REG_RDATA <= ecc_ff;
        `CFE_OFS_ARB_LOST: REG_RDATA <= alc_ff;
        `CFE_OFS_CORE_CTRL: REG_RDATA <= {7'h00, hold_ff};
        `CFE_OFS_CORE_STATUS: REG_RDATA <= {bs_ff, ep_ff, ew_ff, 5'h00};
        default: REG_RDATA <= 8'h00;
      endcase
    end
  end

  assign CORE_HOLD = hold_ff;
  assign BUS_OFF = bs_ff;
  assign FRAME_IRQ = irq_ff[`CFE_BIT_FRAME_FAULT_IRQ_FLAG];

  sequence s_arb_capt;
    ARB_LOST && !alc_lock_ff && CLK_EN;
  endsequence
  a_arb_lock_hold: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    s_arb_capt ##1 (!rd_alc)[*2] |-> $stable(alc_ff))
    else $error("arb capture changed while locked");
  a_arb_flag_set: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    s_arb_capt |=> fes_ff[`CFE_BIT_ARB] && alc_ff[4:0] == $past(ARB_LOST_POS))
    else $error("arb flag or position not captured");
  a_arb_high_zero: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    alc_ff[7:5] == 3'h0) else $error("arb capture high bits set");
  a_bus_error_flag_code: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    BUS_ERR && !ecc_lock_ff && CLK_EN |=>
      ecc_ff == {$past(BUS_ERR_TYPE), $past(BUS_ERR_RX),
      $past(BUS_ERR_FIELD)} && fes_ff[`CFE_BIT_BUS_ERROR_FLAG])
    else $error("bus error code wrong");
  a_bus_off_change_flag_entry: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    CLK_EN && bus_off_change_flag_enter |=> bs_ff && hold_ff && txc_ff == 8'h7f &&
      rxc_ff == 8'h00 && fes_ff[`CFE_BIT_BUS_OFF_CHANGE_FLAG])
    else $error("bus-off entry wrong");
  a_ep_level: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    CLK_EN && (txc_ff[7] || rxc_ff[7]) |=> ep_ff)
    else $error("passive bit missing");
  a_tx_wr_block: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    wr_tx && !hold_ff && !bs_ff && !TX_ERR_INC && !TX_ERR_INC8 &&
      !TX_ERR_DEC |=> txc_ff == $past(txc_ff))
    else $error("tx counter written outside reset mode");
  a_set_wins: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    CLK_EN && wr_stat && REG_WDATA[`CFE_BIT_WARN] &&
      fes_set[`CFE_BIT_WARN] |=> fes_ff[`CFE_BIT_WARN])
    else $error("set lost to clear");
  a_frame_fault_irq_flag_set: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    CLK_EN && |(fes_set & fee_ff) |=> FRAME_IRQ)
    else $error("frame irq not raised");
endmodule // cfe_frame_err

/* File: bench/cfe_node_model.sv */
// cfe_node_model: far-side stand-in for bit engine and other bus nodes
// assumes: tasks called one at a time from the bench, negedge driving
`timescale 1ns/1ps
module cfe_node_model (
  input wire logic clk,
  output logic [10:0] ev,
  output logic [4:0] arg,
  output logic [1:0] ety,
  output logic erx
);
  // ev: 0 bus err, 1 arb lost, 2 tx+1, 3 tx+8, 4 rx+1, 5 tx-1, 6 rx-1,
  // 7 bus free, 8 rx byte, 9 rx eof, 10 pre-buffer drained
  initial begin
    ev = '0;
    arg = '0;
    ety = '0;
    erx = 1'b0;
  end
  // one-cycle strobe; qualifiers flip afterwards so stale values never match
  task automatic pulse(input int k, input logic [4:0] a,
    input logic [1:0] t, input logic r);
    @(negedge clk);
    ev[k] = 1'b1;
    arg = a;
    ety = t;
    erx = r;
    @(negedge clk);
    ev[k] = 1'b0;
    arg = ~a;
    ety = ~t;
    erx = ~r;
  endtask
  // limitation: bus-free spacing is two clocks, not eleven bit times
  task automatic burst(input int k, input int n);
    repeat (n) pulse(k, 5'h00, 2'd0, 1'b0);
  endtask
endmodule // cfe_node_model

/* File: bench/cfe_frame_err_tb.sv */
// cfe_frame_err_tb: self-checking bench for the frame-error top
// assumes: cfe_pkg compiled first, node model drives all bus strobes
`timescale 1ns/1ps
module cfe_frame_err_tb;
  import cfe_pkg::*;
  logic core_clk, reset_n, reg_wr, reg_rd, tx_done, rx_done;
  logic msg_err, rx_full, core_hold, bus_off, frame_irq;
  cfe_addr_t reg_addr;
  cfe_byte_t reg_wdata;
  logic [7:0] reg_rdata, d;
  logic [10:0] ev;
  logic [4:0] arg;
  logic [1:0] ety;
  logic erx;
  int bad_count, checks, cyc;
  // error code rows: type 7:6, rx 5, field 4:0 (sof, crc seq, ovld, ifs)
  cfe_byte_t rows [4] = '{8'h03, 8'h68, 8'h9c, 8'hf2};

  cfe_node_model u_node (.clk(core_clk), .ev(ev), .arg(arg), .ety(ety),
    .erx(erx));
  cfe_frame_err u_dut (.CORE_CLK(core_clk), .RESET_N(reset_n),
    .CLK_EN(1'b1), .REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .BUS_ERR(ev[0]),
    .BUS_ERR_TYPE(cfe_err_type_t'(ety)), .BUS_ERR_RX(erx),
    .BUS_ERR_FIELD(arg), .ARB_LOST(ev[1]), .ARB_LOST_POS(arg),
    .TX_ERR_INC(ev[2]), .TX_ERR_INC8(ev[3]), .RX_ERR_INC(ev[4]),
    .TX_ERR_DEC(ev[5]), .RX_ERR_DEC(ev[6]), .BUS_FREE(ev[7]),
    .RX_BYTE(ev[8]), .RX_EOF(ev[9]), .PREBUF_DRAINED(ev[10]),
    .MSG_ERR_SET(msg_err), .RX_FULL_SET(rx_full), .TX_DONE(tx_done),
    .RX_DONE(rx_done), .CORE_HOLD(core_hold), .BUS_OFF(bus_off),
    .FRAME_IRQ(frame_irq));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic print_verdict();
    if (bad_count == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // far longer than the whole sequence needs
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic chk(input string n, input logic [7:0] e,
    input logic [7:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic rd(input cfe_addr_t a, output logic [7:0] v);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    v = reg_rdata;
  endtask

  task automatic wr(input cfe_addr_t a, input cfe_byte_t v);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask

  task automatic rdc(input cfe_addr_t a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    chk($sformatf("reg %h", a), e, v);
  endtask

  task automatic pins(input logic bo, input logic ho, input logic fi);
    chk("bus_off", {7'h00, bo}, {7'h00, bus_off});
    chk("core_hold", {7'h00, ho}, {7'h00, core_hold});
    chk("frame_irq", {7'h00, fi}, {7'h00, frame_irq});
  endtask

  initial begin
    {reg_wr, reg_rd, tx_done, rx_done, msg_err, rx_full} = '0;
    reg_addr = '0;
    reg_wdata = '0;
    reset_n = 1'b0;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    reset_n = 1'b1;
    // ordinary cases: bus error and arbitration capture per row
    wr(10'h22e, 8'h3f);
    wr(10'h27c, 8'h00);
    for (int i = 0; i < 4; i++) begin
      u_node.pulse(0, rows[i][4:0], rows[i][7:6], rows[i][5]);
      u_node.pulse(0, ~rows[i][4:0], ~rows[i][7:6], ~rows[i][5]);
      u_node.pulse(1, rows[i][4:0], 2'd0, 1'b0);
      u_node.pulse(1, ~rows[i][4:0], 2'd0, 1'b0);
      rdc(10'h22c, 8'h18);
      pins(1'b0, 1'b0, 1'b1);
      rdc(10'h278, rows[i]);
      rdc(10'h27a, {3'b000, rows[i][4:0]});
      rdc(10'h22c, 8'h00);
      wr(10'h228, 8'h10);
      rdc(10'h228, 8'h00);
    end
    // reset values, and flags that still set with enables off
    reset_n = 1'b0;
    @(negedge core_clk);
    reset_n = 1'b1;
    pins(1'b0, 1'b1, 1'b0);
    rdc(10'h228, 8'h00);
    rdc(10'h22e, 8'h00);
    rdc(10'h276, 8'h60);
    u_node.pulse(0, 5'h08, 2'd1, 1'b1);
    rdc(10'h22c, 8'h08);
    pins(1'b0, 1'b1, 1'b0);
    rdc(10'h278, 8'h68);
    wr(10'h22e, 8'h3f);
    rdc(10'h22e, 8'h3f);
    wr(10'h27c, 8'h00);
    // pre-buffer: held frame, next frame overflows on its 14th byte
    u_node.burst(8, 13);
    u_node.pulse(9, 5'h00, 2'd0, 1'b0);
    u_node.burst(8, 13);
    rdc(10'h22c, 8'h00);
    u_node.pulse(8, 5'h00, 2'd0, 1'b0);
    rdc(10'h22c, 8'h20);
    wr(10'h228, 8'h10);
    pins(1'b0, 1'b0, 1'b1);
    wr(10'h22c, 8'h20);
    rdc(10'h22c, 8'h00);
    u_node.pulse(9, 5'h00, 2'd0, 1'b0);
    u_node.pulse(10, 5'h00, 2'd0, 1'b0);
    wr(10'h228, 8'h10);
    // other irq sources: pulses latch, done levels mirror
    @(negedge core_clk);
    {msg_err, rx_full, tx_done, rx_done} = 4'hf;
    @(negedge core_clk);
    {msg_err, rx_full} = 2'b00;
    rdc(10'h228, 8'h0f);
    {tx_done, rx_done} = 2'b00;
    wr(10'h228, 8'h0c);
    rdc(10'h228, 8'h00);
    // warning and passive levels with their change flags
    u_node.burst(3, 12);
    rdc(10'h27d, 8'h20);
    rdc(10'h22c, 8'h02);
    wr(10'h22c, 8'h02);
    u_node.pulse(5, 5'h00, 2'd0, 1'b0);
    rdc(10'h27d, 8'h00);
    rdc(10'h22c, 8'h02);
    wr(10'h274, 8'h55);
    rdc(10'h274, 8'h5f);
    u_node.burst(3, 4);
    u_node.pulse(2, 5'h00, 2'd0, 1'b0);
    rdc(10'h27d, 8'h60);
    rdc(10'h22c, 8'h03);
    wr(10'h22c, 8'h03);
    u_node.pulse(5, 5'h00, 2'd0, 1'b0);
    rdc(10'h22c, 8'h01);
    wr(10'h22c, 8'h3f);
    // error-caused bus-off and full 128-event recovery
    u_node.burst(3, 17);
    pins(1'b1, 1'b1, 1'b1);
    rdc(10'h274, 8'h7f);
    rdc(10'h275, 8'h00);
    rdc(10'h27d, 8'ha0);
    rdc(10'h22c, 8'h05);
    wr(10'h22c, 8'h3f);
    wr(10'h27c, 8'h00);
    u_node.burst(7, 127);
    pins(1'b1, 1'b0, 1'b1);
    u_node.pulse(7, 5'h00, 2'd0, 1'b0);
    pins(1'b0, 1'b0, 1'b1);
    rdc(10'h274, 8'h00);
    rdc(10'h22c, 8'h06);
    wr(10'h22c, 8'h3f);
    // forced bus-off, then quick recovery from a written count
    wr(10'h27c, 8'h01);
    wr(10'h274, 8'hff);
    wr(10'h27c, 8'h00);
    @(negedge core_clk);
    pins(1'b1, 1'b1, 1'b1);
    rdc(10'h274, 8'h7f);
    wr(10'h274, 8'h10);
    wr(10'h27c, 8'h00);
    u_node.pulse(7, 5'h00, 2'd0, 1'b0);
    pins(1'b0, 1'b0, 1'b1);
    rdc(10'h274, 8'h00);
    print_verdict();
  end
endmodule // cfe_frame_err_tb
